//--- hdl/ac_link_dac_pkg.sv
// constants and types shared by the ac-link slot logic
//
// Overview of operation
// - select low: slots 3,4 feed converter
// - select floating: slots 6,9 feed converter
// - select high: slots 7,8 feed converter
// - surround and centre modes: bit clock is input
// - slot 5 modem data is ignored
// - slot 2 commands otherwise ignored
// - return slot 0 bit 15 is ready
// - twelve tag bits follow ready flag
// - return stream msb first, zero stuffed
// - slot 1: zero, index echo, zeros
// - read reply tags slots 1 and 2
// - slot 2: data 19..4, else zero
// - status data only returns identification words
// - return slots 3 to 12 all zero
// - no link power-down mode offered
// - no mixer, volume, mute, power registers
// - identification words at 7Ch and 7Eh
// - drive on rising, sample on falling edge
// - other register reads return zero
package ac_link_dac_pkg;

  // ---------------------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  SLOT_TAG        = 4'h0;
  localparam logic [3:0]  SLOT_CMD_ADDR   = 4'h1;
  localparam logic [3:0]  SLOT_CMD_DATA   = 4'h2;
  localparam logic [3:0]  SLOT_FRONT_L    = 4'h3;
  localparam logic [3:0]  SLOT_FRONT_R    = 4'h4;
  localparam logic [3:0]  SLOT_MODEM      = 4'h5;
  localparam logic [3:0]  SLOT_CENTRE     = 4'h6;
  localparam logic [3:0]  SLOT_SURR_L     = 4'h7;
  localparam logic [3:0]  SLOT_SURR_R     = 4'h8;
  localparam logic [3:0]  SLOT_LOW_FREQ   = 4'h9;
  localparam logic [3:0]  SLOT_LAST       = 4'hC;
  localparam int          SLOT_WIDTH      = 20;
  localparam int          TAG_WIDTH       = 16;
  localparam logic [4:0]  TAG_FIRST_POS   = 5'h0F;
  localparam logic [4:0]  DATA_FIRST_POS  = 5'h13;
  localparam logic [4:0]  TAG_SLOT1_POS   = 5'h0E;
  localparam logic [4:0]  TAG_SLOT2_POS   = 5'h0D;
  localparam int          READY_BIT       = 15;
  localparam int          CMD_RW_BIT      = 19;
  localparam int          IDX_MSB         = 18;
  localparam int          IDX_LSB         = 12;
  localparam int          DATA_MSB        = 19;
  localparam int          DATA_LSB        = 4;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [6:0]  IDX_FACTORY_TEST      = 7'h5A;
  localparam logic [6:0]  IDX_MAKER_CODE_FIRST  = 7'h7C;
  localparam logic [6:0]  IDX_MAKER_CODE_SECOND = 7'h7E;
  localparam logic [15:0] FACTORY_TEST_RESET    = 16'h0000;
  // identification words: arbitrary neutral values
  localparam logic [15:0] MAKER_FIRST_DEFAULT   = 16'h4142;
  localparam logic [15:0] MAKER_SECOND_DEFAULT  = 16'h4301;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int          SYS_CLK_KHZ        = 25000;
  localparam int          BIT_CLK_KHZ        = 12288;
  localparam int          HALF_RAW           = SYS_CLK_KHZ / (2 * BIT_CLK_KHZ);
  localparam logic [3:0]  BIT_CLK_HALF_COUNT = 4'((HALF_RAW < 1) ? 1 : HALF_RAW);

  // ---------------------------------------------------------------------------
  // slot selection
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FRONT,
    MODE_CENTRE_LOW_FREQ,
    MODE_SURROUND
  } mode_type;

endpackage : ac_link_dac_pkg

//--- hdl/ac_link_stereo_dac_slot_logic.sv
// ac-link slot logic for a two-channel playback converter
`timescale 1ns/100ps
`default_nettype none
module ac_link_stereo_dac_slot_logic
  import ac_link_dac_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE_FIRST  = ac_link_dac_pkg::MAKER_FIRST_DEFAULT,
  parameter logic [15:0] MAKER_CODE_SECOND = ac_link_dac_pkg::MAKER_SECOND_DEFAULT
)
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      reset_low_pin_i,
  input  wire logic                      slot_select_hi_i,
  input  wire logic                      slot_select_lo_i,
  input  wire logic                      bit_clk_i,
  output var  logic                      bit_clk_o,
  output var  logic                      bit_clk_oe_n_o,
  input  wire logic                      sync_i,
  input  wire logic                      sdata_out_i,
  output var  logic                      sdata_in_o,
  output var  ac_link_dac_pkg::mode_type mode_o,
  output var  logic [19:0]               dac_left_o,
  output var  logic [19:0]               dac_right_o,
  output var  logic                      dac_strobe_o,
  output var  logic                      dac_ready_o,
  output var  logic [15:0]               test_mode_o
);

  // ---------------------------------------------------------------------------
  // link domain state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        rst_m1;
    logic        rst_m2;
    mode_type    mode_m1;
    mode_type    mode_m2;
    mode_type    mode_m3;
    mode_type    mode;
    logic        prev_sync;
    logic        in_frame;
    logic [3:0]  slot;
    logic [4:0]  bitpos;
    logic [19:0] shift;
    logic [15:0] tags;
    logic        ready;
    logic        rd_pend;
    logic [6:0]  rd_idx;
    logic        wr_pend;
    logic [6:0]  wr_idx;
    logic        resp_valid;
    logic [6:0]  resp_idx;
    logic [15:0] test_reg;
    logic [19:0] left;
    logic [19:0] right;
    logic        strobe;
    logic        tx_next;
  } link_state_type;

  link_state_type state_q;
  link_state_type state_d;
  logic           sdata_in_q;
  logic           link_rst;
  mode_type       sys_mode;

  // ---------------------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------------------

  // tag bit of an outgoing slot
  function automatic logic tag_of(input logic [15:0] tags, input logic [3:0] slot);
    logic [3:0] pos;
    pos    = 4'(READY_BIT) - slot;
    tag_of = tags[pos];
  endfunction : tag_of

  // readback value by register index
  function automatic logic [15:0] read_value(input logic [6:0] idx);
    read_value = 16'h0000;
    if (idx == IDX_MAKER_CODE_FIRST)
      read_value = MAKER_CODE_FIRST;
    else if (idx == IDX_MAKER_CODE_SECOND)
      read_value = MAKER_CODE_SECOND;
  endfunction : read_value

  // outgoing slot routed to the left converter input
  function automatic logic [3:0] left_slot(input mode_type mode);
    unique case (mode)
      MODE_FRONT:
        left_slot = SLOT_FRONT_L;
      MODE_CENTRE_LOW_FREQ:
        left_slot = SLOT_CENTRE;
      MODE_SURROUND:
        left_slot = SLOT_SURR_L;
      default:
        left_slot = SLOT_TAG;                    // illegal code routes nothing
    endcase
  endfunction : left_slot

  // outgoing slot routed to the right converter input
  function automatic logic [3:0] right_slot(input mode_type mode);
    unique case (mode)
      MODE_FRONT:
        right_slot = SLOT_FRONT_R;
      MODE_CENTRE_LOW_FREQ:
        right_slot = SLOT_LOW_FREQ;
      MODE_SURROUND:
        right_slot = SLOT_SURR_R;
      default:
        right_slot = SLOT_TAG;                   // illegal code routes nothing
    endcase
  endfunction : right_slot

  // return stream bit for a slot and bit position
  function automatic logic tx_bit(input logic [3:0]  slot,
                                  input logic [4:0]  bitpos,
                                  input logic        ready,
                                  input logic        resp_valid,
                                  input logic [6:0]  resp_idx);
    logic [19:0] word;
    word   = 20'h00000;
    tx_bit = 1'b0;
    if (slot == SLOT_TAG)
    begin
      if (bitpos == TAG_FIRST_POS)
        tx_bit = ready;
      else if (bitpos == TAG_SLOT1_POS || bitpos == TAG_SLOT2_POS)
        tx_bit = resp_valid;
    end
    else if (slot == SLOT_CMD_ADDR && resp_valid)
    begin
      word[IDX_MSB:IDX_LSB] = resp_idx;
      tx_bit = word[bitpos];
    end
    else if (slot == SLOT_CMD_DATA && resp_valid)
    begin
      word[DATA_MSB:DATA_LSB] = read_value(resp_idx);
      tx_bit = word[bitpos];
    end
    // slots 3 to 12 stay zero
  endfunction : tx_bit

  // ---------------------------------------------------------------------------
  // system domain: pin decode and master bit clock
  // ---------------------------------------------------------------------------
  slot_select_decoder u_decoder (
    .clk_sys_i        (clk_sys_i),
    .sys_rst_i        (sys_rst_i),
    .slot_select_hi_i (slot_select_hi_i),
    .slot_select_lo_i (slot_select_lo_i),
    .mode_o           (sys_mode)
  );

  bit_clock_divider u_divider (
    .clk_sys_i      (clk_sys_i),
    .sys_rst_i      (sys_rst_i),
    .drive_en_i     (sys_mode == MODE_FRONT),
    .bit_clk_o      (bit_clk_o),
    .bit_clk_oe_n_o (bit_clk_oe_n_o)
  );

  assign mode_o   = sys_mode;
  assign link_rst = state_q.rst_m2;

  // ---------------------------------------------------------------------------
  // link domain next state, evaluated at each falling bit clock edge
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [19:0] word;
    logic        last;
    logic        start;
    word    = {state_q.shift[18:0], sdata_out_i};
    last    = (state_q.bitpos == 5'h00);
    start   = sync_i && !state_q.prev_sync;
    state_d = state_q;

    // crossings: reset pin and slot selection
    state_d.rst_m1    = !reset_low_pin_i;
    state_d.rst_m2    = state_q.rst_m1;
    state_d.mode_m1   = sys_mode;
    state_d.mode_m2   = state_q.mode_m1;
    state_d.mode_m3   = state_q.mode_m2;
    if (state_q.mode_m2 == state_q.mode_m3)
      state_d.mode = state_q.mode_m3;
    state_d.prev_sync = sync_i;
    state_d.strobe    = 1'b0;

    if (start)
    begin
      // frame start seen on sync; next rising edge carries slot 0 bit 15
      state_d.in_frame   = 1'b1;
      state_d.slot       = SLOT_TAG;
      state_d.bitpos     = TAG_FIRST_POS;
      state_d.ready      = 1'b1;
      state_d.resp_valid = state_q.rd_pend;
      state_d.resp_idx   = state_q.rd_idx;
      state_d.rd_pend    = 1'b0;
      state_d.wr_pend    = 1'b0;
    end
    else if (state_q.in_frame)
    begin
      state_d.shift = word;
      if (last)
      begin
        unique case (state_q.slot)
          SLOT_TAG:
            state_d.tags = word[TAG_WIDTH-1:0];
          SLOT_CMD_ADDR:
            if (tag_of(state_q.tags, SLOT_CMD_ADDR))
            begin
              if (word[CMD_RW_BIT])
              begin
                state_d.rd_pend = 1'b1;
                state_d.rd_idx  = word[IDX_MSB:IDX_LSB];
              end
              else
              begin
                state_d.wr_pend = 1'b1;
                state_d.wr_idx  = word[IDX_MSB:IDX_LSB];
              end
            end
          SLOT_CMD_DATA:
            // only the test register stores write data
            if (state_q.wr_pend && tag_of(state_q.tags, SLOT_CMD_DATA)
                && state_q.wr_idx == IDX_FACTORY_TEST)
              state_d.test_reg = word[DATA_MSB:DATA_LSB];
          SLOT_FRONT_L, SLOT_CENTRE, SLOT_SURR_L:
            if (tag_of(state_q.tags, state_q.slot)
                && state_q.slot == left_slot(state_q.mode))
              state_d.left = word;
          SLOT_FRONT_R, SLOT_SURR_R, SLOT_LOW_FREQ:
            if (state_q.slot == right_slot(state_q.mode))
            begin
              state_d.strobe = 1'b1;
              if (tag_of(state_q.tags, state_q.slot))
                state_d.right = word;
            end
          default:
            // modem slot and the remaining slots are dropped
            state_d.shift = word;
        endcase
        if (state_q.slot == SLOT_LAST)
          state_d.in_frame = 1'b0;
        else
        begin
          state_d.slot   = state_q.slot + 4'h1;
          state_d.bitpos = DATA_FIRST_POS;
        end
      end
      else
        state_d.bitpos = state_q.bitpos - 5'h01;
    end

    // bit for the next rising edge, msb first
    state_d.tx_next = state_d.in_frame
                      && tx_bit(state_d.slot, state_d.bitpos, state_d.ready,
                                state_d.resp_valid, state_d.resp_idx);
  end

  // link state register on the falling edge, where link data is sampled
  always_ff @(negedge bit_clk_i)
  begin
    if (link_rst)
    begin
      state_q            <= '0;
      state_q.rst_m1     <= state_d.rst_m1;
      state_q.rst_m2     <= state_d.rst_m2;
      state_q.mode_m1    <= MODE_CENTRE_LOW_FREQ;
      state_q.mode_m2    <= MODE_CENTRE_LOW_FREQ;
      state_q.mode_m3    <= MODE_CENTRE_LOW_FREQ;
      state_q.mode       <= MODE_CENTRE_LOW_FREQ;
      state_q.test_reg   <= FACTORY_TEST_RESET;
    end
    else
      state_q <= state_d;
  end

  // return data changes on the rising edge
  always_ff @(posedge bit_clk_i)
  begin
    if (link_rst)
      sdata_in_q <= 1'b0;
    else
      sdata_in_q <= state_q.tx_next;
  end

  // ---------------------------------------------------------------------------
  // outputs; no power-down path exists
  // ---------------------------------------------------------------------------
  assign sdata_in_o   = sdata_in_q;
  assign dac_left_o   = state_q.left;
  assign dac_right_o  = state_q.right;
  assign dac_strobe_o = state_q.strobe;
  assign dac_ready_o  = state_q.ready;
  assign test_mode_o  = state_q.test_reg;

endmodule : ac_link_stereo_dac_slot_logic
`default_nettype wire

//--- hdl/bit_clock_divider.sv
// bit clock generator for the clock master selection
`timescale 1ns/100ps
`default_nettype none
module bit_clock_divider
  import ac_link_dac_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic drive_en_i,
  output var  logic bit_clk_o,
  output var  logic bit_clk_oe_n_o
);

  typedef struct packed {
    logic [3:0] count;
    logic       level;
    logic       oe_n;
  } div_state_type;

  div_state_type state_q;
  div_state_type state_d;

  // ---------------------------------------------------------------------------
  // toggle every half period while master, release pin otherwise
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_d      = state_q;
    state_d.oe_n = !drive_en_i;
    if (!drive_en_i)
    begin
      state_d.count = 4'h0;
      state_d.level = 1'b0;
    end
    else if (state_q.count == BIT_CLK_HALF_COUNT - 4'h1)
    begin
      state_d.count = 4'h0;
      state_d.level = !state_q.level;
    end
    else
      state_d.count = state_q.count + 4'h1;
  end

  // state register
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      state_q <= '{count: 4'h0, level: 1'b0, oe_n: 1'b1};
    else
      state_q <= state_d;
  end

  assign bit_clk_o      = state_q.level;
  assign bit_clk_oe_n_o = state_q.oe_n;

endmodule : bit_clock_divider
`default_nettype wire

//--- hdl/slot_select_decoder.sv
// three-level slot select pin decoder
`timescale 1ns/100ps
`default_nettype none
module slot_select_decoder
  import ac_link_dac_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      slot_select_hi_i,
  input  wire logic                      slot_select_lo_i,
  output var  ac_link_dac_pkg::mode_type mode_o
);

  typedef struct packed {
    logic     hi_m1;
    logic     hi_m2;
    logic     lo_m1;
    logic     lo_m2;
    mode_type mode;
  } dec_state_type;

  dec_state_type state_q;
  dec_state_type state_d;

  // ---------------------------------------------------------------------------
  // synchronise pad comparators, then classify the level
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_d       = state_q;
    state_d.hi_m1 = slot_select_hi_i;
    state_d.hi_m2 = state_q.hi_m1;
    state_d.lo_m1 = slot_select_lo_i;
    state_d.lo_m2 = state_q.lo_m1;
    if (state_q.lo_m2 && !state_q.hi_m2)
      state_d.mode = MODE_FRONT;
    else if (state_q.hi_m2 && !state_q.lo_m2)
      state_d.mode = MODE_SURROUND;
    else
      state_d.mode = MODE_CENTRE_LOW_FREQ;
  end

  // state register; floating is the safe default, clock not driven
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      state_q <= '{hi_m1: 1'b0, hi_m2: 1'b0, lo_m1: 1'b0, lo_m2: 1'b0,
                   mode: MODE_CENTRE_LOW_FREQ};
    else
      state_q <= state_d;
  end

  assign mode_o = state_q.mode;

endmodule : slot_select_decoder
`default_nettype wire

//--- sim/ac_link_ctrl_model.sv
// behavioural ac-link controller on the far side of the link
`timescale 1ns/100ps
`default_nettype none
module ac_link_ctrl_model
(
  input  wire logic        bit_clk_i,
  input  wire logic        go_i,
  input  wire logic [19:0] tx_i [13],
  input  wire logic        sdata_in_i,
  output var  logic        sync_o,
  output var  logic        sdata_o,
  output var  logic        busy_o,
  output var  logic [19:0] rx_o [13]
);
  int cnt = 0;
  int k;
  int j;
  assign busy_o = (cnt != 0);
  initial
  begin
    sync_o = 1'b0;
    sdata_o = 1'b0;
  end
  // launch: sync and data change on the rising edge
  always @(posedge bit_clk_i)
  begin
    k = cnt - 1;
    if (cnt == 0)
    begin
      sdata_o <= !sdata_o; // idle line never rests on one value
      if (go_i)
      begin
        sync_o <= 1'b1;
        cnt <= 1;
      end
    end
    else
    begin
      if (k < 16)
        sdata_o <= tx_i[0][15-k];
      else if (k < 256)
        sdata_o <= tx_i[(k-16)/20+1][19-(k-16)%20];
      if (cnt == 16)
        sync_o <= 1'b0; // sixteen clocks of sync
      cnt <= (cnt == 257) ? 0 : cnt + 1;
    end
  end
  // capture: return bits sampled on the falling edge
  always @(negedge bit_clk_i)
  begin
    j = cnt - 2;
    if (j >= 0 && j < 16)
      rx_o[0][15-j] <= sdata_in_i;
    else if (j >= 16 && j < 256)
      rx_o[(j-16)/20+1][19-(j-16)%20] <= sdata_in_i;
  end
endmodule : ac_link_ctrl_model
`default_nettype wire

//--- sim/ac_link_slot_sva.sv
// assertions on the ports of the ac-link slot logic
`timescale 1ns/100ps
`default_nettype none
module ac_link_slot_sva
  import ac_link_dac_pkg::*;
(
  input wire logic                      clk_sys_i,
  input wire logic                      sys_rst_i,
  input wire logic                      reset_low_pin_i,
  input wire logic                      slot_select_hi_i,
  input wire logic                      slot_select_lo_i,
  input wire logic                      bit_clk_i,
  input wire logic                      bit_clk_oe_n_o,
  input wire logic                      sync_i,
  input wire logic                      sdata_in_o,
  input wire ac_link_dac_pkg::mode_type mode_o,
  input wire logic                      dac_ready_o
);
  int unsigned pos_q = 0;
  // --------
  // bit position since frame start
  // --------
  always_ff @(negedge bit_clk_i)
  begin
    if (!reset_low_pin_i)
      pos_q <= 0;
    else if ($rose(sync_i))
      pos_q <= 1;
    else if (pos_q != 0 && pos_q < 300)
      pos_q <= pos_q + 1;
  end
  // --------
  // system domain
  // --------
  chk_oe_front_only: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !bit_clk_oe_n_o |-> mode_o == MODE_FRONT || $past(mode_o) == MODE_FRONT)
    else $error("bit clock driven outside front mode");
  chk_mode_front: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (slot_select_lo_i && !slot_select_hi_i) [*6] |-> mode_o == MODE_FRONT)
    else $error("low select pin not decoded as front");
  // --------
  // link domain, sampled like the controller
  // --------
  chk_ready_at_frame: assert property (@(negedge bit_clk_i) disable iff (!reset_low_pin_i)
    $rose(sync_i) |-> ##[1:2] dac_ready_o)
    else $error("ready not set after frame start");
  chk_tag_zeros: assert property (@(negedge bit_clk_i) disable iff (!reset_low_pin_i)
    $rose(sync_i) |-> ##4 !sdata_in_o [*8] ##1 !sdata_in_o [*5])
    else $error("unused tag bit set");
  chk_reply_tag_pair: assert property (@(negedge bit_clk_i) disable iff (!reset_low_pin_i)
    $rose(sync_i) |-> ##3 sdata_in_o == $past(sdata_in_o))
    else $error("slot 1 and slot 2 tags differ");
  chk_slot1_zeros: assert property (@(negedge bit_clk_i) disable iff (!reset_low_pin_i)
    $rose(sync_i) |-> ##17 !sdata_in_o ##8 !sdata_in_o [*8] ##1 !sdata_in_o [*4])
    else $error("slot 1 reserved bit set");
  chk_slot2_low: assert property (@(negedge bit_clk_i) disable iff (!reset_low_pin_i)
    $rose(sync_i) |-> ##53 !sdata_in_o [*4])
    else $error("slot 2 low bits set");
  chk_unused_slots: assert property (@(negedge bit_clk_i) disable iff (!reset_low_pin_i)
    pos_q >= 57 && pos_q <= 256 |-> !sdata_in_o)
    else $error("return slots 3 to 12 not zero");
endmodule : ac_link_slot_sva
bind ac_link_stereo_dac_slot_logic ac_link_slot_sva ac_link_slot_sva_inst (.clk_sys_i,
  .sys_rst_i, .reset_low_pin_i, .slot_select_hi_i, .slot_select_lo_i, .bit_clk_i,
  .bit_clk_oe_n_o, .sync_i, .sdata_in_o, .mode_o, .dac_ready_o);
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the ac-link slot logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ac_link_dac_pkg::*;
  // identification words: arbitrary values
  localparam logic [15:0] ID1 = 16'h4E51;
  localparam logic [15:0] ID2 = 16'h5203;
  logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, reset_low_pin_i = 1'b0, ext_clk = 1'b0;
  logic        slot_select_hi_i = 1'b0, slot_select_lo_i = 1'b1, go = 1'b0;
  logic        busy, sync_i, sdata_out_i, sdata_in_o, bit_clk_o, bit_clk_oe_n_o;
  logic        dac_strobe_o, dac_ready_o;
  logic [15:0] test_mode_o;
  logic [19:0] dac_left_o, dac_right_o, tx [13], rx [13];
  mode_type    mode_o;
  int          fails = 0, checks_done = 0, cyc = 0, strobes = 0;
  // pad level: device clock when driven, else the master's
  wire logic   bit_clk_i = bit_clk_oe_n_o ? ext_clk : bit_clk_o;

  ac_link_stereo_dac_slot_logic #(.MAKER_CODE_FIRST(ID1), .MAKER_CODE_SECOND(ID2))
    ac_link_stereo_dac_slot_logic_inst (.clk_sys_i, .sys_rst_i, .reset_low_pin_i,
    .slot_select_hi_i, .slot_select_lo_i, .bit_clk_i, .bit_clk_o, .bit_clk_oe_n_o, .sync_i,
    .sdata_out_i, .sdata_in_o, .mode_o, .dac_left_o, .dac_right_o, .dac_strobe_o,
    .dac_ready_o, .test_mode_o);
  ac_link_ctrl_model ac_link_ctrl_model_inst (.bit_clk_i, .go_i(go), .tx_i(tx),
    .sdata_in_i(sdata_in_o), .sync_o(sync_i), .sdata_o(sdata_out_i), .busy_o(busy), .rx_o(rx));

  initial forever #20 clk_sys_i = !clk_sys_i;
  initial
  begin
    #7;
    forever #80 ext_clk = !ext_clk;
  end
  // count converter strobes, one per frame
  always @(posedge dac_strobe_o)
    strobes++;
  // hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // one whole frame through the controller model
  task automatic frame();
    go = 1'b1;
    for (int i = 0; i < 2000 && !busy; i++)
      @(negedge clk_sys_i);
    go = 1'b0;
    for (int i = 0; i < 2000 && busy; i++)
      @(negedge clk_sys_i);
    repeat (4) @(negedge clk_sys_i);
  endtask : frame

  // distinct zero-filled sample per slot, all tagged valid
  task automatic fill(input logic [3:0] m);
    tx[0] = 20'hFFF8;
    for (int s = 1; s < 13; s++)
      tx[s] = {4'(s), m, 12'h000};
  endtask : fill

  task automatic test_front();
    check(20'(sdata_in_o), 20'h0);
    check(20'(dac_ready_o), 20'h0);
    check(20'(test_mode_o), 20'(FACTORY_TEST_RESET));
    check(20'(mode_o), 20'(MODE_FRONT));
    check(20'(bit_clk_oe_n_o), 20'h0);
    fill(4'h1);
    tx[1] = {1'b1, IDX_MAKER_CODE_FIRST, 12'h000};
    frame();
    check(dac_left_o, tx[3]);
    check(dac_right_o, tx[4]);
    check(20'(dac_ready_o), 20'h1);
    check(20'(strobes), 20'h1);
    tx[0] = 20'h8000;
    frame();
    check(20'(rx[0][15:0]), 20'hE000);
    check(rx[1], {1'b0, IDX_MAKER_CODE_FIRST, 12'h000});
    check(rx[2], {ID1, 4'h0});
    for (int s = 3; s < 13; s++)
      check(rx[s], 20'h0);
    frame();
    check(20'(rx[0][15:0]), 20'h8000);
    check(rx[2], 20'h0);
    $display("test_front done");
  endtask : test_front

  task automatic test_regs();
    logic [6:0]  idx [3];
    logic [15:0] val [3];
    idx = '{IDX_FACTORY_TEST, IDX_MAKER_CODE_SECOND, 7'h26};
    val = '{16'h0000, ID2, 16'h0000};
    tx[0] = 20'hE000;
    tx[1] = {1'b0, IDX_FACTORY_TEST, 12'h000};
    tx[2] = {16'h3C96, 4'h0};
    frame();
    check(20'(test_mode_o), 20'h3C96);
    for (int i = 0; i < 4; i++)
    begin
      tx[0] = (i < 3) ? 20'hC000 : 20'h8000;
      tx[1] = {1'b1, idx[i%3], 12'h000};
      frame();
      if (i > 0)
      begin
        check(rx[1], {1'b0, idx[i-1], 12'h000});
        check(rx[2], {val[i-1], 4'h0});
      end
    end
    $display("test_regs done");
  endtask : test_regs

  task automatic test_modes();
    logic [19:0] exp_l, exp_r;
    for (int m = 0; m < 2; m++)
    begin
      slot_select_lo_i = 1'b0;
      slot_select_hi_i = m[0];
      repeat (40) @(negedge clk_sys_i);
      check(20'(mode_o), m ? 20'(MODE_SURROUND) : 20'(MODE_CENTRE_LOW_FREQ));
      check(20'(bit_clk_oe_n_o), 20'h1);
      check(20'(bit_clk_o), 20'h0);
      fill(4'(m + 2));
      frame();
      frame();
      exp_l = m ? tx[7] : tx[6];
      exp_r = m ? tx[8] : tx[9];
      check(dac_left_o, exp_l);
      check(dac_right_o, exp_r);
      tx[0] = 20'h8000;
      for (int s = 1; s < 13; s++)
        tx[s] = ~tx[s];
      frame();
      check(dac_left_o, exp_l);
      check(dac_right_o, exp_r);
    end
    check(20'(test_mode_o), 20'h3C96);
    check(20'(strobes), 20'h0E);
    $display("test_modes done");
  endtask : test_modes

  initial
  begin
    for (int s = 0; s < 13; s++)
      tx[s] = 20'h0;
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (40) @(negedge clk_sys_i);
    reset_low_pin_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    test_front();
    test_regs();
    test_modes();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
